// ### bench/etc_cpu_model.sv
// processor core model: apb master and interrupt acknowledge pulses
`timescale 1ns/1ps

module etc_cpu_model (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             overflow_ack,
  output logic             compare_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    overflow_ack = 1'b0;
    compare_ack  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle count assumed, the bench watchdog bounds this
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle interrupt-executed pulse, c picks the compare flag
  task automatic ack(input logic c);
    @(posedge clk_sys);
    if (c) begin
      compare_ack <= 1'b1;
    end else begin
      overflow_ack <= 1'b1;
    end
    @(posedge clk_sys);
    compare_ack  <= 1'b0;
    overflow_ack <= 1'b0;
  endtask : ack

endmodule : etc_cpu_model

// ### bench/etc_timer_tb.sv
// self-checking bench of the timer block
`timescale 1ns/1ps
`include "etc_defs.svh"

module etc_timer_tb;

  typedef struct packed {
    logic        w;  // write when high
    logic [11:0] a;  // byte address
    logic [31:0] d;  // write data or expected read
    logic        er; // expected pslverr
  } etc_row_type;

  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        overflow_ack, compare_ack, compare_output, xtal, erv;
  logic        overflow_irq, compare_irq;
  int          failures, samples_checked, n;

  // register walk: reset values, access kinds, refusal
  etc_row_type rows [17] = '{
    '{1'b0, `ETC_OFF_COUNT,   32'h00, 1'b0},
    '{1'b0, `ETC_OFF_COMPARE, 32'h00, 1'b0},
    '{1'b0, `ETC_OFF_CONTROL, 32'h00, 1'b0},
    '{1'b0, `ETC_OFF_ASYNC,   32'h00, 1'b0},
    '{1'b0, `ETC_OFF_FLAG,    32'h00, 1'b0},
    '{1'b0, `ETC_OFF_MASK,    32'h00, 1'b0},
    '{1'b1, `ETC_OFF_COUNT,   32'h5A, 1'b0},
    '{1'b0, `ETC_OFF_COUNT,   32'h5A, 1'b0},
    '{1'b1, `ETC_OFF_COMPARE, 32'h33, 1'b0},
    '{1'b0, `ETC_OFF_COMPARE, 32'h33, 1'b0},
    '{1'b1, `ETC_OFF_MASK,    32'h03, 1'b0},
    '{1'b0, `ETC_OFF_MASK,    32'h03, 1'b0},
    '{1'b1, `ETC_OFF_CONTROL, 32'h80, 1'b0},
    '{1'b0, `ETC_OFF_CONTROL, 32'h00, 1'b0},
    '{1'b0, 12'h018,          32'h00, 1'b1},
    '{1'b1, 12'h018,          32'hFF, 1'b1},
    '{1'b0, `ETC_OFF_COUNT,   32'h5A, 1'b0}
  };

  etc_timer i_etc_timer (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .crystal_osc_pin_one(xtal), .overflow_ack, .compare_ack,
    .compare_output, .overflow_irq, .compare_irq);

  etc_cpu_model i_etc_cpu_model (.clk_sys, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .overflow_ack,
    .compare_ack);

  ////////////////////////////////////////////////////////////////////////////
  // 10 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // compare seen against expected, count both outcomes
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, s, x);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_etc_cpu_model.xfer(1'b1, a, d, rdv, erv);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    i_etc_cpu_model.xfer(1'b0, a, 32'h0, rdv, erv);
    check(rdv, x);
  endtask : rd

  // output state, looked at once the write has landed
  task automatic co(input logic x);
    repeat (2) @(posedge clk_sys);
    check({31'h0, compare_output}, {31'h0, x});
  endtask : co

  // bounded wait on one interrupt line
  task automatic wait_irq(input logic c);
    for (n = 0; n < 600; n++) begin
      if ((c ? compare_irq : overflow_irq) === 1'b1) break;
      @(posedge clk_sys);
    end
    // a line that never rose counts as a mismatch
    check({31'h0, c ? compare_irq : overflow_irq}, 32'h1);
  endtask : wait_irq

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    xtal = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      i_etc_cpu_model.xfer(rows[i].w, rows[i].a, rows[i].d, rdv, erv);
      if (!rows[i].w) check(rdv, rows[i].d);
      check({31'h0, erv}, {31'h0, rows[i].er});
    end
    co(1'b0);
    // normal mode wrap: both flags, then acknowledge each
    wr(`ETC_OFF_COUNT, 32'hF0);
    wr(`ETC_OFF_COMPARE, 32'hF5);
    wr(`ETC_OFF_CONTROL, 32'h01);
    wait_irq(1'b0);
    wr(`ETC_OFF_CONTROL, 32'h00);
    rd(`ETC_OFF_FLAG, 32'h03);
    i_etc_cpu_model.ack(1'b0);
    @(posedge clk_sys);
    check({31'h0, overflow_irq}, 32'h0);
    i_etc_cpu_model.ack(1'b1);
    @(posedge clk_sys);
    check({31'h0, compare_irq}, 32'h0);
    // count written equal to compare: the match must be swallowed
    wr(`ETC_OFF_COMPARE, 32'h10);
    wr(`ETC_OFF_COUNT, 32'h10);
    wr(`ETC_OFF_CONTROL, 32'h01);
    wr(`ETC_OFF_CONTROL, 32'h00);
    rd(`ETC_OFF_FLAG, 32'h00);
    // clear-on-match keeps the count at or below compare
    wr(`ETC_OFF_COUNT, 32'h00);
    wr(`ETC_OFF_COMPARE, 32'h03);
    wr(`ETC_OFF_CONTROL, 32'h11);
    wait_irq(1'b1);
    wr(`ETC_OFF_CONTROL, 32'h00);
    i_etc_cpu_model.xfer(1'b0, `ETC_OFF_COUNT, 32'h0, rdv, erv);
    check({31'h0, rdv <= 32'h03}, 32'h1);
    rd(`ETC_OFF_FLAG, 32'h02);
    wr(`ETC_OFF_FLAG, 32'h02);
    rd(`ETC_OFF_FLAG, 32'h00);
    // force strobe: toggle, clear, set, then mode changes
    wr(`ETC_OFF_COUNT, 32'h77);
    wr(`ETC_OFF_CONTROL, 32'hA0);
    co(1'b1);
    rd(`ETC_OFF_FLAG, 32'h00);
    rd(`ETC_OFF_COUNT, 32'h77);
    wr(`ETC_OFF_CONTROL, 32'hC0);
    co(1'b0);
    wr(`ETC_OFF_CONTROL, 32'hE0);
    co(1'b1);
    wr(`ETC_OFF_CONTROL, 32'h68);
    co(1'b1);
    wr(`ETC_OFF_CONTROL, 32'hC8);
    co(1'b1);
    // fast pwm: buffered compare, old active value still matches
    wr(`ETC_OFF_CONTROL, 32'h00);
    wr(`ETC_OFF_COMPARE, 32'h20);
    wr(`ETC_OFF_CONTROL, 32'h08);
    wr(`ETC_OFF_COMPARE, 32'h80);
    rd(`ETC_OFF_COMPARE, 32'h80);
    wr(`ETC_OFF_COUNT, 32'h1F);
    wr(`ETC_OFF_CONTROL, 32'h09);
    wr(`ETC_OFF_CONTROL, 32'h08);
    rd(`ETC_OFF_FLAG, 32'h02);
    // phase correct: up to max, turn, overflow back at bottom
    wr(`ETC_OFF_COUNT, 32'hFC);
    wr(`ETC_OFF_CONTROL, 32'h19);
    wr(`ETC_OFF_CONTROL, 32'h18);
    rd(`ETC_OFF_COUNT, 32'hFE);
    wr(`ETC_OFF_CONTROL, 32'h19);
    wait_irq(1'b0);
    wr(`ETC_OFF_CONTROL, 32'h18);
    // masking the compare request leaves its flag set
    wr(`ETC_OFF_MASK, 32'h01);
    @(posedge clk_sys);
    check({31'h0, compare_irq}, 32'h0);
    check({31'h0, overflow_irq}, 32'h1);
    rd(`ETC_OFF_FLAG, 32'h03);
    // crystal pin as tick source, five rising edges
    wr(`ETC_OFF_CONTROL, 32'h00);
    wr(`ETC_OFF_COUNT, 32'h00);
    wr(`ETC_OFF_ASYNC, 32'h01);
    wr(`ETC_OFF_CONTROL, 32'h01);
    repeat (10) begin
      repeat (4) @(posedge clk_sys);
      xtal <= ~xtal;
    end
    repeat (4) @(posedge clk_sys);
    wr(`ETC_OFF_CONTROL, 32'h00);
    rd(`ETC_OFF_COUNT, 32'h05);
    // second reset in mid-run
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(`ETC_OFF_ASYNC, 32'h00);
    co(1'b0);
    tally_and_finish();
  end

endmodule : etc_timer_tb

// ### design/etc_defs.svh
// offsets, field positions, reset values and counts of the timer block
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

// register byte offsets on the apb bus
`define ETC_OFF_COUNT    12'h000
`define ETC_OFF_COMPARE  12'h004
`define ETC_OFF_CONTROL  12'h008
`define ETC_OFF_ASYNC    12'h00C
`define ETC_OFF_FLAG     12'h010
`define ETC_OFF_MASK     12'h014

// control register field positions
`define ETC_CTRL_CS_LSB    0
`define ETC_CTRL_MODE_LSB  3
`define ETC_CTRL_COM_LSB   5
`define ETC_CTRL_FORCE_BIT 7

// async register, flag and mask bit positions
`define ETC_ASYNC_SEL_BIT  0
`define ETC_FLAG_OVF_BIT   0
`define ETC_FLAG_CMP_BIT   1

// counter extremes
`define ETC_BOTTOM 8'h00
`define ETC_MAX    8'hFF

// reset value of every register
`define ETC_RESET_BYTE 8'h00

// prescaler tap masks, one per divide ratio
`define ETC_DIV1_MASK    10'h000
`define ETC_DIV8_MASK    10'h007
`define ETC_DIV32_MASK   10'h01F
`define ETC_DIV64_MASK   10'h03F
`define ETC_DIV128_MASK  10'h07F
`define ETC_DIV256_MASK  10'h0FF
`define ETC_DIV1024_MASK 10'h3FF

`endif

// ### design/etc_pkg.sv
// types shared by the timer block
package etc_pkg;

  // waveform mode select encodings
  typedef enum logic [1:0] {
    ETC_NORMAL = 2'h0,
    ETC_FAST   = 2'h1,
    ETC_CTC    = 2'h2,
    ETC_PHASE  = 2'h3
  } etc_mode_type;

  // all state of the main timer module
  typedef struct packed {
    logic [7:0]   cnt;        // timer_count
    logic [7:0]   ocr;        // active compare_value
    logic [7:0]   ocr_buf;    // compare_value buffer
    logic [2:0]   cs;         // clock_source_select
    etc_mode_type mode;       // waveform_mode_select
    logic [1:0]   com;        // compare_output_action
    logic         async_sel;  // async_clock_select
    logic         ovf_flag;   // overflow_flag
    logic         cmp_flag;   // compare_flag
    logic         mask_ovf;   // overflow interrupt enable
    logic         mask_cmp;   // compare_interrupt_enable
    logic         dir_down;   // phase correct slope
    logic         block;      // match blocked after count write
    logic         oc;         // compare_output state
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         ovf_irq;
    logic         cmp_irq;
  } etc_state_type;

  // all state of the tick generator
  typedef struct packed {
    logic [9:0] presc;    // prescaler count
    logic       pin_prev; // last crystal pin level
  } etc_tick_state_type;

endpackage : etc_pkg

// ### design/etc_tick_gen.sv
// timer tick source select and prescaler
`timescale 1ns/1ps
`include "etc_defs.svh"

module etc_tick_gen #(
  parameter int PRESC_BITS = 10
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       async_clock_select,
  input  wire logic [2:0] clock_source_select,
  input  wire logic       crystal_osc_pin_one,
  output logic            timer_tick
);
  import etc_pkg::*;

  // the widest tap needs ten prescaler bits
  if (PRESC_BITS != 10) begin : g_bad_presc
    $error("etc_tick_gen: PRESC_BITS must be 10");
  end

  etc_tick_state_type st;       // registered state
  etc_tick_state_type nx;       // next state
  logic               src_en;   // one source edge this cycle
  logic [9:0]         tap_mask; // prescaler bits that must be all ones

  //////////////////////////////////////////////////////////////////////////
  // source edge and tap selection
  always_comb begin
    nx = st;
    // io clock by default, crystal rising edges when selected
    src_en = async_clock_select ? (crystal_osc_pin_one & ~st.pin_prev)
                                : 1'b1;
    nx.pin_prev = crystal_osc_pin_one;
    if (src_en) begin
      nx.presc = st.presc + 10'h001;
    end
    unique case (clock_source_select)
      3'h1:    tap_mask = `ETC_DIV1_MASK;
      3'h2:    tap_mask = `ETC_DIV8_MASK;
      3'h3:    tap_mask = `ETC_DIV32_MASK;
      3'h4:    tap_mask = `ETC_DIV64_MASK;
      3'h5:    tap_mask = `ETC_DIV128_MASK;
      3'h6:    tap_mask = `ETC_DIV256_MASK;
      default: tap_mask = `ETC_DIV1024_MASK;
    endcase
    // no source selected: no tick at all
    timer_tick = (clock_source_select != 3'h0) & src_en
               & ((st.presc & tap_mask) == tap_mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

endmodule : etc_tick_gen

// ### design/etc_timer.sv
// eight bit timer with one compare channel behind an apb slave
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "etc_defs.svh"

// Operation
// - tick from io clock, or crystal pin
// - clock source zero stops the counter
// - count register accessible, cpu write wins
// - detect bottom, max, and mode dependent top
// - mode bits pick clear, up or down
// - match sets compare flag on next tick
// - compare flag requests interrupt, ack or w1c
// - pwm modes double buffer compare value
// - cpu reaches buffer or compare register
// - force strobe acts like match outside the pwm modes, no flag
// - count write blocks next tick's match
// - output state survives mode changes
// - output action bits act immediately
// - overflow flag per mode, requests interrupt
// - flags and masks in shared registers
// - normal mode counts up, overflow wrapping
// - clear-on-match mode clears at compare
// - fast pwm counts bottom to max
// - action zero leaves output unchanged
module etc_timer (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_osc_pin_one,
  input  wire logic        overflow_ack,
  input  wire logic        compare_ack,
  output logic             compare_output,
  output logic             overflow_irq,
  output logic             compare_irq
);
  import etc_pkg::*;

  etc_state_type st;          // registered state
  etc_state_type nx;          // next state
  logic          timer_tick;  // one cycle per counted tick
  logic          acc;         // apb access phase
  logic          done;        // apb transfer completes at this edge
  logic          wr;          // write completes
  logic          wr_cnt;      // write to timer_count
  logic          wr_cmp;      // write to compare_value
  logic          wr_ctl;      // write to timer_control_reg
  logic          force_wr;    // force strobe accepted
  logic          hit;         // address maps to a register
  logic [31:0]   rdata;       // read mux
  logic          is_pwm;      // double buffering active
  logic          at_bottom;   // counter at bottom
  logic          at_max;      // counter at max
  logic [7:0]    top_val;     // top of the sequence
  logic          match;       // comparator output
  logic          cmp_event;   // match not blocked
  logic          ovf_set;     // overflow event this cycle
  logic          cmp_set;     // compare event this cycle
  logic          ovf_clr;     // overflow flag clear
  logic          cmp_clr;     // compare flag clear
  logic [1:0]    new_com;     // action bits being written
  etc_mode_type  new_mode;    // mode being written

  //////////////////////////////////////////////////////////////////////////
  // tick source and prescaler
  etc_tick_gen #(
    .PRESC_BITS (10)
  ) u_tick (
    .clk_sys             (clk_sys),
    .reset               (reset),
    .async_clock_select  (st.async_sel),
    .clock_source_select (st.cs),
    .crystal_osc_pin_one (crystal_osc_pin_one),
    .timer_tick          (timer_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // comparator and extreme value detection
  always_comb begin
    at_bottom = (st.cnt == `ETC_BOTTOM);
    at_max    = (st.cnt == `ETC_MAX);
    // only clear-on-match takes its top from the compare value
    top_val   = (st.mode == ETC_CTC) ? st.ocr : `ETC_MAX;
    is_pwm    = (st.mode == ETC_FAST) | (st.mode == ETC_PHASE);
    // comparator runs every cycle, tick or not
    match     = (st.cnt == st.ocr);
    // a count write masks the match of the following tick
    cmp_event = match & ~st.block;
  end

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  always_comb begin
    acc      = psel & penable;
    // one wait state keeps pready and prdata straight from flops
    done     = acc & st.pready;
    wr       = done & pwrite;
    wr_cnt   = wr & (paddr == `ETC_OFF_COUNT);
    wr_cmp   = wr & (paddr == `ETC_OFF_COMPARE);
    wr_ctl   = wr & (paddr == `ETC_OFF_CONTROL);
    new_com  = pwdata[`ETC_CTRL_COM_LSB +: 2];
    new_mode = etc_mode_type'(pwdata[`ETC_CTRL_MODE_LSB +: 2]);
    // force works only when the written mode is not pwm
    force_wr = wr_ctl & pwdata[`ETC_CTRL_FORCE_BIT]
             & ((new_mode == ETC_NORMAL) | (new_mode == ETC_CTC));
    hit      = 1'b1;
    rdata    = 32'h0000_0000;
    unique case (paddr)
      `ETC_OFF_COUNT:   rdata[7:0] = st.cnt;
      // buffer when double buffered, else the live register
      `ETC_OFF_COMPARE: rdata[7:0] = is_pwm ? st.ocr_buf
                                            : st.ocr;
      `ETC_OFF_CONTROL: begin
        // force strobe always reads back zero
        rdata[`ETC_CTRL_CS_LSB +: 3]   = st.cs;
        rdata[`ETC_CTRL_MODE_LSB +: 2] = st.mode;
        rdata[`ETC_CTRL_COM_LSB +: 2]  = st.com;
      end
      `ETC_OFF_ASYNC:   rdata[`ETC_ASYNC_SEL_BIT] = st.async_sel;
      `ETC_OFF_FLAG: begin
        rdata[`ETC_FLAG_OVF_BIT] = st.ovf_flag;
        rdata[`ETC_FLAG_CMP_BIT] = st.cmp_flag;
      end
      `ETC_OFF_MASK: begin
        rdata[`ETC_FLAG_OVF_BIT] = st.mask_ovf;
        rdata[`ETC_FLAG_CMP_BIT] = st.mask_cmp;
      end
      default:          hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nx      = st;
    ovf_set = 1'b0;
    cmp_set = 1'b0;

    // apb handshake: data and error latched in the first access cycle
    nx.pready = acc & ~st.pready;
    if (acc & ~st.pready) begin
      nx.prdata  = rdata;
      nx.pslverr = ~hit;
    end

    // counting; with no tick the counter simply holds
    if (timer_tick) begin
      nx.block = 1'b0;
      unique case (st.mode)
        ETC_NORMAL: begin
          // plain up count, wraps max to bottom
          nx.cnt  = st.cnt + 8'h01;
          ovf_set = at_max;
        end
        ETC_FAST: begin
          // single slope, bottom to max and round again
          nx.cnt  = st.cnt + 8'h01;
          ovf_set = at_max;
        end
        ETC_CTC: begin
          // clear at top, which is the compare value
          if (st.cnt == top_val) begin
            nx.cnt = `ETC_BOTTOM;
          end else begin
            nx.cnt = st.cnt + 8'h01;
          end
          ovf_set = at_max;
        end
        ETC_PHASE: begin
          // dual slope; overflow on reaching bottom
          if (!st.dir_down) begin
            if (at_max) begin
              nx.dir_down = 1'b1;
              nx.cnt      = st.cnt - 8'h01;
            end else begin
              nx.cnt      = st.cnt + 8'h01;
            end
          end else if (at_bottom) begin
            nx.dir_down = 1'b0;
            nx.cnt      = st.cnt + 8'h01;
            ovf_set     = 1'b1;
          end else begin
            nx.cnt      = st.cnt - 8'h01;
          end
        end
      endcase

      // compare flag lands on the tick after the match
      if (cmp_event) begin
        cmp_set = 1'b1;
        // action bits are read live, never buffered
        unique case (st.mode)
          ETC_NORMAL, ETC_CTC: begin
            unique case (st.com)
              2'h0: nx.oc = st.oc;
              2'h1: nx.oc = ~st.oc;
              2'h2: nx.oc = 1'b0;
              2'h3: nx.oc = 1'b1;
            endcase
          end
          ETC_FAST: begin
            if (st.com[1]) begin
              nx.oc = st.com[0];
            end
          end
          ETC_PHASE: begin
            // up slope like fast pwm, down slope inverted
            if (st.com[1]) begin
              nx.oc = st.com[0] ^ st.dir_down;
            end
          end
        endcase
      end

      // bottom end of the fast pwm period
      if ((st.mode == ETC_FAST) && at_max) begin
        if (st.com[1]) begin
          nx.oc = ~st.com[0];
        end
        // reload at the wrap so each period sees one value
        nx.ocr = st.ocr_buf;
      end
      // phase correct reloads at top
      if ((st.mode == ETC_PHASE) && at_max && !st.dir_down) begin
        nx.ocr = st.ocr_buf;
      end
    end

    // processor count write overrides clear and count
    if (wr_cnt) begin
      nx.cnt   = pwdata[7:0];
      nx.block = 1'b1;
    end

    // compare value: buffer in pwm, live register otherwise
    if (wr_cmp) begin
      nx.ocr_buf = pwdata[7:0];
      if (!is_pwm) begin
        nx.ocr = pwdata[7:0];
      end
    end

    // control; mode change leaves the output state alone
    if (wr_ctl) begin
      nx.cs   = pwdata[`ETC_CTRL_CS_LSB +: 3];
      nx.mode = new_mode;
      nx.com  = new_com;
    end
    // forced match moves the output only, with written bits
    if (force_wr) begin
      unique case (new_com)
        2'h0: nx.oc = st.oc;
        2'h1: nx.oc = ~st.oc;
        2'h2: nx.oc = 1'b0;
        2'h3: nx.oc = 1'b1;
      endcase
    end

    if (wr & (paddr == `ETC_OFF_ASYNC)) begin
      nx.async_sel = pwdata[`ETC_ASYNC_SEL_BIT];
    end
    if (wr & (paddr == `ETC_OFF_MASK)) begin
      nx.mask_ovf = pwdata[`ETC_FLAG_OVF_BIT];
      nx.mask_cmp = pwdata[`ETC_FLAG_CMP_BIT];
    end

    // flags: one to clear or interrupt ack, but a set wins
    ovf_clr = overflow_ack
            | (wr & (paddr == `ETC_OFF_FLAG) & pwdata[`ETC_FLAG_OVF_BIT]);
    cmp_clr = compare_ack
            | (wr & (paddr == `ETC_OFF_FLAG) & pwdata[`ETC_FLAG_CMP_BIT]);
    nx.ovf_flag = (st.ovf_flag & ~ovf_clr) | ovf_set;
    nx.cmp_flag = (st.cmp_flag & ~cmp_clr) | cmp_set;

    // requests follow the flags through their masks
    nx.ovf_irq = nx.ovf_flag & nx.mask_ovf;
    nx.cmp_irq = nx.cmp_flag & nx.mask_cmp;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; reset zeroes every field
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from the state flops
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign compare_output = st.oc;
  assign overflow_irq   = st.ovf_irq;
  assign compare_irq    = st.cmp_irq;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_stopped_hold: assert property (
    (st.cs == 3'h0 && !wr_cnt) |=> $stable(st.cnt))
    else $error("counter moved with no clock source");

  chk_write_wins: assert property (
    wr_cnt |=> (st.cnt == $past(pwdata[7:0])))
    else $error("count write lost to tick");

  chk_normal_step: assert property (
    (timer_tick && st.mode == ETC_NORMAL && !wr_cnt)
      |=> (st.cnt == $past(st.cnt) + 8'h01))
    else $error("normal mode did not count up by one");

  chk_flag_on_tick: assert property (
    (timer_tick && cmp_event) |=> st.cmp_flag)
    else $error("compare flag not set after match tick");

  chk_match_block: assert property (
    wr_cnt ##1 timer_tick |-> !cmp_event)
    else $error("match not blocked after count write");

  chk_irq_gate: assert property (
    compare_irq == (st.cmp_flag && st.mask_cmp))
    else $error("compare request missing while enabled");

  chk_buffer_hold: assert property (
    (is_pwm && !(timer_tick && at_max)) |=> $stable(st.ocr))
    else $error("pwm compare value changed off the period edge");

  chk_force_noflag: assert property (
    (force_wr && !(timer_tick && cmp_event)) |=> !$rose(st.cmp_flag))
    else $error("force strobe set the compare flag");

  chk_force_toggle: assert property (
    (force_wr && new_com == 2'h1 && !timer_tick) |=> $changed(st.oc))
    else $error("forced toggle left output unchanged");

  chk_null_action: assert property (
    (st.com == 2'h0 && !wr_ctl) |=> $stable(st.oc))
    else $error("output moved with action zero");

  chk_normal_ovf: assert property (
    (timer_tick && st.mode == ETC_NORMAL && at_max && !wr_cnt)
      |=> (st.ovf_flag && st.cnt == `ETC_BOTTOM))
    else $error("overflow flag missing at wrap");

endmodule : etc_timer
